// ==== inc/dts_pkg.sv ====
// constants, types and decode helpers shared by the debug trigger/status block
`default_nettype none

package dts_pkg;

    // ==========================================================
    // register map (byte addresses on the plain register port)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TRIG = 8'h01;
    localparam logic [7:0] ADDR_STAT = 8'h02;
    localparam logic [7:0] ADDR_IST  = 8'h03;
    localparam logic [7:0] ADDR_IMSK = 8'h04;

    // ==========================================================
    // field positions
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_ARM_BIT  = 6;
    localparam int TRG_TAG_BIT   = 7;
    localparam int TRG_BEGIN_BIT = 6;
    localparam int STS_AF_BIT    = 7;
    localparam int STS_BF_BIT    = 6;
    localparam int STS_ARMED_STATUS_FLAG_BIT  = 5;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_TRIG_BIT  = 1;
    localparam int IRQ_W         = 2;

    // ==========================================================
    // reset values and counts
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] TRIG_RST   = 8'h00;
    localparam logic [3:0] FIFO_WORDS = 4'h8;

    // ==========================================================
    // trigger mode codes
    localparam logic [3:0] MODE_A_ONLY    = 4'h0;
    localparam logic [3:0] MODE_A_OR_B    = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B  = 4'h2;
    localparam logic [3:0] MODE_EVT_B     = 4'h3;
    localparam logic [3:0] MODE_A_EVT_B   = 4'h4;
    localparam logic [3:0] MODE_A_AND_B   = 4'h5;
    localparam logic [3:0] MODE_A_NOT_B   = 4'h6;
    localparam logic [3:0] MODE_INSIDE    = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE   = 4'h8;

    // ==========================================================
    // run phases
    typedef enum logic [1:0] {
        DTS_IDLE,
        DTS_WAIT,
        DTS_STORE,
        DTS_CIRC
    } dts_phase_t;

    // event-only modes store one byte per triggering b event (after an a hit in MODE_A_EVT_B)
    function automatic logic is_evt_only(input logic [3:0] mode);
        is_evt_only = (mode == MODE_EVT_B) || (mode == MODE_A_EVT_B);
    endfunction

endpackage

`default_nettype wire

// ==== inc/dts_trg_if.sv ====
// trigger decode signals between the run controller and the mode decoder
`timescale 1ns/10ps
`default_nettype none

interface dts_trg_if;
    logic [3:0] mode;
    logic       tag;
    logic       acc;
    logic       op_exec;
    logic       match_a;
    logic       match_b;
    logic       ge_a;
    logic       le_b;
    logic       a_seen;
    logic       hit_a;
    logic       hit_b;
    logic       trig;

    modport dec (
        input  mode, tag, acc, op_exec, match_a, match_b, ge_a, le_b, a_seen,
        output hit_a, hit_b, trig
    );
    modport ctl (
        output mode, tag, acc, op_exec, match_a, match_b, ge_a, le_b, a_seen,
        input  hit_a, hit_b, trig
    );
endinterface

`default_nettype wire

// ==== rtl/dts_trig_dec.sv ====
// combinational trigger mode decoder
`timescale 1ns/10ps
`default_nettype none

module dts_trig_dec (
    dts_trg_if.dec t
);

    logic qual;
    logic in_rng;

    // ==========================================================
    // qualify comparator hits and pick the mode's trigger term
    always_comb begin
        qual    = t.tag ? t.op_exec : t.acc;                 // RL2
        t.hit_a = qual & t.match_a;
        t.hit_b = qual & t.match_b;
        in_rng  = t.ge_a & t.le_b;
        case (t.mode)
            dts_pkg::MODE_A_ONLY:   t.trig = t.hit_a;        // RL5
            dts_pkg::MODE_A_OR_B:   t.trig = t.hit_a | t.hit_b;
            dts_pkg::MODE_A_THEN_B: t.trig = t.a_seen & t.hit_b;
            dts_pkg::MODE_EVT_B:    t.trig = t.hit_b;
            dts_pkg::MODE_A_EVT_B:  t.trig = t.a_seen & t.hit_b;
            dts_pkg::MODE_A_AND_B:  t.trig = t.hit_a & t.match_b;
            dts_pkg::MODE_A_NOT_B:  t.trig = t.hit_a & ~t.match_b;
            dts_pkg::MODE_INSIDE:   t.trig = qual & in_rng;  // RL6
            dts_pkg::MODE_OUTSIDE:  t.trig = qual & ~in_rng; // RL6
            default:                t.trig = 1'b0;           // RL7
        endcase
    end

endmodule

`default_nettype wire

// ==== rtl/dts_irq.sv ====
// sticky event flags, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none

module dts_irq #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] evt,
    input  wire logic         wr_clr,
    input  wire logic         wr_msk,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] status,
    output logic      [W-1:0] mask,
    output logic              irq
);

    typedef struct packed {
        logic [W-1:0] st;
        logic [W-1:0] mk;
        logic         irq;
    } dts_irq_state_t;

    dts_irq_state_t r_reg;
    dts_irq_state_t r_next;

    // ==========================================================
    // write one clears, a new event wins over the clear
    always_comb begin
        r_next = r_reg;
        for (int i = 0; i < W; i++) begin
            if (wr_clr && wdata[i]) begin
                r_next.st[i] = 1'b0;
            end
            if (evt[i]) begin
                r_next.st[i] = 1'b1;
            end
        end
        if (wr_msk) begin
            r_next.mk = wdata;
        end
        r_next.irq = |(r_next.st & r_next.mk);
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign status = r_reg.st;
    assign mask   = r_reg.mk;
    assign irq    = r_reg.irq;

endmodule

`default_nettype wire

// ==== rtl/dts_top.sv ====
// debug trigger selection, run control and status reporting
`timescale 1ns/10ps
`default_nettype none

// How it works
// RL1 - trigger register writable only when disarmed, bits 4-5 zero
// RL2 - bit 7 picks force or tag qualification
// RL3 - bit 6 picks end or begin trace
// RL4 - event-only modes always run as begin trace
// RL5 - mode codes 0000 to 0110 as listed
// RL6 - 0111 inside range, 1000 outside range
// RL7 - codes 1001 to 1111 never trigger
// RL8 - a flag cleared at start, set on a match
// RL9 - b flag cleared at start, set on b match
// RL10 - armed flag mirrors arm control bit
// RL11 - run ends on full begin trace or end trigger
// RL12 - writing arm or enable low ends the run
// RL13 - count cleared at start, reports up to eight
// RL14 - count never decrements on fifo reads
// RL15 - status register ignores writes
// RL16 - begin bit 0 end trace, 1 begin trace
// RL17 - event-only words carry data in low byte only

module dts_top #(
    parameter logic [3:0] FIFO_DEPTH = dts_pkg::FIFO_WORDS
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       acc_valid,
    input  wire logic       op_exec,
    input  wire logic       cmp_a_hit,
    input  wire logic       cmp_b_hit,
    input  wire logic       addr_ge_a,
    input  wire logic       addr_le_b,
    input  wire logic       cap_req,
    output logic            store_word,
    output logic            store_low_only,
    output logic            armed,
    output logic            irq
);

    // ==========================================================
    // state
    typedef struct packed {
        logic               en;
        logic               arm;
        logic               tag;
        logic               begin_sel;
        logic [3:0]         mode;
        logic               af;
        logic               bf;
        logic [3:0]         cnt;
        dts_pkg::dts_phase_t ph;
        logic [7:0]         rdata;
        logic               store;
        logic               lo_only;
    } dts_state_t;

    dts_state_t r_reg;
    dts_state_t r_next;

    dts_trg_if t ();

    logic [dts_pkg::IRQ_W-1:0] irq_evt;
    logic [dts_pkg::IRQ_W-1:0] irq_st;
    logic [dts_pkg::IRQ_W-1:0] irq_mk;
    logic                      wr_ctrl;
    logic                      wr_trig;
    logic                      evt_mode;
    logic                      eff_begin;
    logic                      do_store;
    logic                      done;
    logic [3:0]                cnt_inc;
    logic [7:0]                ctrl_val;
    logic [7:0]                trig_val;
    logic [7:0]                stat_val;

    // ==========================================================
    // decoder hookup
    assign t.mode    = r_reg.mode;
    assign t.tag     = r_reg.tag;
    assign t.acc     = acc_valid;
    assign t.op_exec = op_exec;
    assign t.match_a = cmp_a_hit;
    assign t.match_b = cmp_b_hit;
    assign t.ge_a    = addr_ge_a;
    assign t.le_b    = addr_le_b;
    assign t.a_seen  = r_reg.af;

    dts_trig_dec u_dec (
        .t (t)
    );

    // ==========================================================
    // interrupt flags: run done and trigger seen
    assign irq_evt[dts_pkg::IRQ_DONE_BIT] = done;
    assign irq_evt[dts_pkg::IRQ_TRIG_BIT] = r_reg.arm & t.trig;

    dts_irq #(
        .W (dts_pkg::IRQ_W)
    ) u_irq (
        .clk    (clk),
        .nrst   (nrst),
        .ce     (ce),
        .evt    (irq_evt),
        .wr_clr (wr && addr == dts_pkg::ADDR_IST),
        .wr_msk (wr && addr == dts_pkg::ADDR_IMSK),
        .wdata  (wdata[dts_pkg::IRQ_W-1:0]),
        .status (irq_st),
        .mask   (irq_mk),
        .irq    (irq)
    );

    // ==========================================================
    // register views
    assign wr_ctrl = wr && (addr == dts_pkg::ADDR_CTRL);
    assign wr_trig = wr && (addr == dts_pkg::ADDR_TRIG);

    // trigger register with bits 4 and 5 reading zero
    assign trig_val = {r_reg.tag, r_reg.begin_sel, 2'b00, r_reg.mode}; // RL1

    assign ctrl_val = {r_reg.en, r_reg.arm, 6'h00};

    // status: flags, armed image, count
    assign stat_val = {r_reg.af, r_reg.bf, r_reg.arm, 1'b0, r_reg.cnt}; // RL10

    // ==========================================================
    // run helpers
    assign evt_mode  = dts_pkg::is_evt_only(r_reg.mode);
    assign eff_begin = r_reg.begin_sel | evt_mode;                     // RL4

    // count saturates at the fifo depth
    assign cnt_inc = (r_reg.cnt < FIFO_DEPTH) ? r_reg.cnt + 4'h1 : r_reg.cnt;

    // decide when a word is stored in the current phase
    always_comb begin
        do_store = 1'b0;
        done     = 1'b0;
        case (r_reg.ph)
            dts_pkg::DTS_CIRC: begin
                do_store = cap_req;
                done     = t.trig;                                     // RL11
            end
            dts_pkg::DTS_WAIT: begin
                do_store = t.trig & (evt_mode | cap_req);
                done     = do_store && (cnt_inc == FIFO_DEPTH);        // RL11
            end
            dts_pkg::DTS_STORE: begin
                do_store = evt_mode ? t.trig : cap_req;
                done     = do_store && (cnt_inc == FIFO_DEPTH);        // RL11
            end
            default: begin
                do_store = 1'b0;
                done     = 1'b0;
            end
        endcase
        if (!r_reg.arm) begin
            do_store = 1'b0;
            done     = 1'b0;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        r_next       = r_reg;
        r_next.store = 1'b0;
        r_next.rdata = 8'h00;

        // comparator flags while armed
        if (r_reg.arm && t.hit_a) begin
            r_next.af = 1'b1;                                          // RL8
        end
        if (r_reg.arm && t.hit_b) begin
            r_next.bf = 1'b1;                                          // RL9
        end

        // trigger moves a waiting begin trace into storage
        if (r_reg.arm && r_reg.ph == dts_pkg::DTS_WAIT && t.trig) begin
            r_next.ph = dts_pkg::DTS_STORE;
        end

        // store pulse and word count, never counting down
        if (do_store) begin
            r_next.store = 1'b1;
            r_next.cnt   = cnt_inc;                                    // RL13 RL14
        end

        // completion drops the arm bit
        if (done) begin
            r_next.arm = 1'b0;                                         // RL10 RL11
            r_next.ph  = dts_pkg::DTS_IDLE;
        end

        // control register writes
        if (wr_ctrl) begin
            r_next.en = wdata[dts_pkg::CTRL_EN_BIT];
            if (!wdata[dts_pkg::CTRL_EN_BIT] || !wdata[dts_pkg::CTRL_ARM_BIT]) begin
                r_next.arm = 1'b0;                                     // RL12
                r_next.ph  = dts_pkg::DTS_IDLE;
            end else if (!r_reg.arm) begin
                // start of a run: arm and clear flags and count
                r_next.arm = 1'b1;                                     // RL10
                r_next.af  = 1'b0;                                     // RL8
                r_next.bf  = 1'b0;                                     // RL9
                r_next.cnt = 4'h0;                                     // RL13
                r_next.ph  = eff_begin ? dts_pkg::DTS_WAIT             // RL3 RL16
                                       : dts_pkg::DTS_CIRC;
            end
        end

        // trigger register takes writes only while disarmed
        if (wr_trig && !r_reg.arm) begin                               // RL1
            r_next.tag       = wdata[dts_pkg::TRG_TAG_BIT];            // RL2
            r_next.begin_sel = wdata[dts_pkg::TRG_BEGIN_BIT];          // RL16
            r_next.mode      = wdata[3:0];
        end

        // status register has no write path at all
        // (writes to ADDR_STAT fall through unused)                   // RL15

        // high byte of event-only words is unused
        r_next.lo_only = dts_pkg::is_evt_only(r_next.mode);            // RL17

        // read data, valid the cycle after the strobe
        if (rd) begin
            case (addr)
                dts_pkg::ADDR_CTRL: r_next.rdata = ctrl_val;
                dts_pkg::ADDR_TRIG: r_next.rdata = trig_val;
                dts_pkg::ADDR_STAT: r_next.rdata = stat_val;
                dts_pkg::ADDR_IST:  r_next.rdata = {6'h00, irq_st};
                dts_pkg::ADDR_IMSK: r_next.rdata = {6'h00, irq_mk};
                default:            r_next.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg           <= '0;
            r_reg.en        <= dts_pkg::CTRL_RST[dts_pkg::CTRL_EN_BIT];
            r_reg.arm       <= dts_pkg::CTRL_RST[dts_pkg::CTRL_ARM_BIT];
            r_reg.tag       <= dts_pkg::TRIG_RST[dts_pkg::TRG_TAG_BIT];
            r_reg.begin_sel <= dts_pkg::TRIG_RST[dts_pkg::TRG_BEGIN_BIT];
            r_reg.mode      <= dts_pkg::TRIG_RST[3:0];
            r_reg.ph        <= dts_pkg::DTS_IDLE;
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign rdata          = r_reg.rdata;
    assign store_word     = r_reg.store;
    assign store_low_only = r_reg.lo_only;
    assign armed          = r_reg.arm;

endmodule

`default_nettype wire

// ==== dv/dts_host_model.sv ====
// host side model: offers capture words and keeps its own tally of stored words
`timescale 1ns/10ps
`default_nettype none

module dts_host_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       go,
    input  wire logic       store_word,
    input  wire logic       armed,
    output logic            cap_req,
    output logic      [3:0] tally
);
    logic arm_q;

    // ==========================================================
    // word offer and tally, tally restarts when a run is armed
    always_ff @(posedge clk) begin
        arm_q <= armed;
        cap_req <= nrst && go;
        if (!nrst || (armed && !arm_q)) begin
            tally <= 4'h0;
        end else if (store_word && tally != 4'hF) begin
            tally <= tally + 4'h1;
        end
    end
endmodule

`default_nettype wire

// ==== dv/dts_top_monitor.sv ====
// port checker for the debug trigger and status block
`timescale 1ns/10ps
`default_nettype none

module dts_monitor #(
    parameter logic [3:0] FIFO_DEPTH = 4'h8
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    input  wire logic       acc_valid,
    input  wire logic       cmp_a_hit,
    input  wire logic       store_word,
    input  wire logic       store_low_only,
    input  wire logic       armed
);
    logic [3:0] mode_sh;
    logic       tag_sh;
    logic       beg_sh;
    logic       twr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // shadow of the trigger register, taken only while disarmed
    assign twr = ce && wr && addr == dts_pkg::ADDR_TRIG && !armed;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_sh <= 4'h0;
            tag_sh <= 1'b0;
            beg_sh <= 1'b0;
        end else if (twr) begin
            mode_sh <= wdata[3:0];
            tag_sh <= wdata[7];
            beg_sh <= wdata[6];
        end
    end

    // ==========================================================
    // assertions
    a_trig_rsv_zero: assert property (ce && rd && addr == dts_pkg::ADDR_TRIG
        |=> rdata[5:4] == 2'b00) else $error("trigger bits 5:4 not zero");
    a_stat_arm_image: assert property (ce && rd && addr == dts_pkg::ADDR_STAT
        |=> rdata[5] == $past(armed)) else $error("armed bit differs");
    a_count_max: assert property (ce && rd && addr == dts_pkg::ADDR_STAT
        |=> rdata[3:0] <= FIFO_DEPTH && !rdata[4]) else $error("count out of range");
    a_store_armed: assert property (store_word |-> $past(armed))
        else $error("store while disarmed");
    a_arm_start: assert property (ce && wr && addr == dts_pkg::ADDR_CTRL
        && wdata[7:6] == 2'b11 && !armed |=> armed) else $error("arm not taken");
    a_manual_stop: assert property (ce && wr && addr == dts_pkg::ADDR_CTRL
        && wdata[7:6] != 2'b11 |=> !armed) else $error("run not stopped");
    a_low_only_mode: assert property (store_low_only ==
        (mode_sh == dts_pkg::MODE_EVT_B || mode_sh == dts_pkg::MODE_A_EVT_B))
        else $error("low byte flag wrong");
    a_end_trig_stop: assert property (armed && mode_sh == 4'h0 && !tag_sh
        && !beg_sh && acc_valid && cmp_a_hit |=> !armed) else $error("no end");
    a_rsv_no_trig: assert property (armed && mode_sh > 4'h8 && !wr |=> armed)
        else $error("reserved mode ended run");

    c_arm: cover property (armed && !$past(armed));
    c_store: cover property (store_word);
    c_low: cover property (store_low_only && store_word);
endmodule

bind dts_top dts_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .acc_valid(acc_valid),
    .cmp_a_hit(cmp_a_hit),
    .store_word(store_word),
    .store_low_only(store_low_only),
    .armed(armed)
);

`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the debug trigger and status block
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic       clk;
    logic       nrst;
    logic       ce;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       acc_valid;
    logic       op_exec;
    logic       cmp_a_hit;
    logic       cmp_b_hit;
    logic       addr_ge_a;
    logic       addr_le_b;
    logic       cap_req;
    logic       store_word;
    logic       store_low_only;
    logic       armed;
    logic       irq;
    logic       go;
    logic [3:0] tally;
    logic [7:0] d;
    logic [3:0] m;
    logic       af;
    logic       hit;
    int         err_total;
    int         checks_done;
    int         seed;
    int         i;

    dts_top uut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .acc_valid(acc_valid), .op_exec(op_exec),
        .cmp_a_hit(cmp_a_hit), .cmp_b_hit(cmp_b_hit), .addr_ge_a(addr_ge_a),
        .addr_le_b(addr_le_b), .cap_req(cap_req), .store_word(store_word),
        .store_low_only(store_low_only), .armed(armed), .irq(irq));
    dts_host_model host (.clk(clk), .nrst(nrst), .go(go), .store_word(store_word),
        .armed(armed), .cap_req(cap_req), .tally(tally));

    // ==========================================================
    // clock, watchdog and helpers
    always #5 clk = ~clk;
    initial begin
        #100000;
        err_total++;
        close_out();
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge clk);
        {acc_valid, op_exec, cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} <= v;
        @(posedge clk);
        {acc_valid, op_exec, cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} <= 6'h00;
    endtask
    function automatic logic [3:0] cnt8(input logic [3:0] t);
        cnt8 = (t > 4'h8) ? 4'h8 : t;
    endfunction
    function automatic logic exp_trig(input logic [3:0] md, input logic a_f,
                                      input logic [4:0] v);
        logic ha;
        logic hb;
        logic rg;
        ha = v[4] & v[3];
        hb = v[4] & v[2];
        rg = v[1] & v[0];
        case (md)
            4'h0: exp_trig = ha;
            4'h1: exp_trig = ha | hb;
            4'h2: exp_trig = a_f & hb;
            4'h5: exp_trig = ha & v[2];
            4'h6: exp_trig = ha & !v[2];
            4'h7: exp_trig = v[4] & rg;
            4'h8: exp_trig = v[4] & !rg;
            default: exp_trig = 1'b0;
        endcase
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {clk, ce, nrst, wr, rd, go, addr, wdata, err_total, checks_done} = '0;
        {acc_valid, op_exec, cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} = 6'h00;
        ce = 1'b1;
        seed = 84278;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 6; i++) rchk(i[7:0], 8'h00);
        for (i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            wr_reg(dts_pkg::ADDR_TRIG, d);
            rchk(dts_pkg::ADDR_TRIG, d & 8'hCF);
        end
        // a write with the clock enable low must leave the register alone
        ce <= 1'b0;
        wr_reg(dts_pkg::ADDR_TRIG, ~d);
        ce <= 1'b1;
        rchk(dts_pkg::ADDR_TRIG, d & 8'hCF);
        wr_reg(dts_pkg::ADDR_STAT, 8'hFF);
        rchk(dts_pkg::ADDR_STAT, 8'h00);
        $display("register test done");
        // end trace: circular fill, a force hit ends it, interrupt path
        wr_reg(dts_pkg::ADDR_TRIG, 8'h00);
        wr_reg(dts_pkg::ADDR_CTRL, 8'hC0);
        go <= 1'b1;
        repeat (12) @(posedge clk);
        go <= 1'b0;
        wr_reg(dts_pkg::ADDR_TRIG, 8'h07);
        rchk(dts_pkg::ADDR_TRIG, 8'h00);
        rchk(dts_pkg::ADDR_STAT, {4'h2, cnt8(tally)});
        pulse(6'h28);
        @(posedge clk);
        #1 chk({7'h00, armed}, 8'h00);
        rchk(dts_pkg::ADDR_STAT, 8'h88);
        chk({7'h00, irq}, 8'h00);
        wr_reg(dts_pkg::ADDR_IMSK, 8'h03);
        rchk(dts_pkg::ADDR_IST, 8'h03);
        chk({7'h00, irq}, 8'h01);
        wr_reg(dts_pkg::ADDR_IST, 8'h03);
        rchk(dts_pkg::ADDR_IST, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("end trace test done");
        // begin trace with tag qualification
        wr_reg(dts_pkg::ADDR_TRIG, 8'hC1);
        wr_reg(dts_pkg::ADDR_CTRL, 8'hC0);
        go <= 1'b1;
        pulse(6'h24);
        repeat (3) @(posedge clk);
        rchk(dts_pkg::ADDR_STAT, 8'h20);
        pulse(6'h14);
        repeat (12) @(posedge clk);
        go <= 1'b0;
        chk({7'h00, armed}, 8'h00);
        chk({4'h0, cnt8(tally)}, 8'h08);
        rchk(dts_pkg::ADDR_STAT, 8'h48);
        $display("begin trace test done");
        // event-only with begin bit clear, stopped by hand
        wr_reg(dts_pkg::ADDR_TRIG, 8'h03);
        #1 chk({7'h00, store_low_only}, 8'h01);
        wr_reg(dts_pkg::ADDR_CTRL, 8'hC0);
        go <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(dts_pkg::ADDR_STAT, 8'h20);
        repeat (3) pulse(6'h24);
        go <= 1'b0;
        wr_reg(dts_pkg::ADDR_CTRL, 8'h80);
        #1 chk({7'h00, armed}, 8'h00);
        rchk(dts_pkg::ADDR_STAT, 8'h43);
        wr_reg(dts_pkg::ADDR_STAT, 8'h00);
        rchk(dts_pkg::ADDR_STAT, 8'h43);
        // a then event-only b: b before a stores nothing, b after a stores one byte
        wr_reg(dts_pkg::ADDR_TRIG, 8'h04);
        wr_reg(dts_pkg::ADDR_CTRL, 8'hC0);
        pulse(6'h24);
        pulse(6'h28);
        pulse(6'h24);
        rchk(dts_pkg::ADDR_STAT, 8'hE1);
        // reset in mid-run drops the run and clears the status
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        #1 chk({7'h00, armed}, 8'h00);
        rchk(dts_pkg::ADDR_STAT, 8'h00);
        $display("event-only test done");
        // random comparator traffic over every non event mode
        for (i = 0; i < 48; i++) begin
            m = 4'($random(seed));
            if (m == 4'h3 || m == 4'h4) m = 4'h9 + i[2:0];
            wr_reg(dts_pkg::ADDR_TRIG, {4'h0, m});
            wr_reg(dts_pkg::ADDR_CTRL, 8'hC0);
            af = 1'b0;
            hit = 1'b0;
            repeat (2) begin
                if (!hit) begin
                    d = 8'($random(seed));
                    @(posedge clk);
                    {acc_valid, cmp_a_hit, cmp_b_hit, addr_ge_a, addr_le_b} <= d[4:0];
                    hit = exp_trig(m, af, d[4:0]);
                    af = af | (d[4] & d[3]);
                end
            end
            pulse(6'h00);
            #1;
            if (m < 4'h7) chk({7'h00, armed}, {7'h00, !hit});
            else if (m < 4'h9) chk({7'h00, armed}, {7'h00, !hit});
            else chk({7'h00, armed}, 8'h01);
            wr_reg(dts_pkg::ADDR_CTRL, 8'h00);
        end
        $display("mode test done");
        close_out();
    end
endmodule

`default_nettype wire
